/* feed_pkg.sv */
package feed_pkg;

  // Clock rate and step timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned FEED_PPS = 640;
  localparam int unsigned NOPAPER_PPS = 125;
  // Least step period at 640 pps, rounded up
  localparam int unsigned MIN_STEP_CYC = (CLK_HZ + FEED_PPS - 1) / FEED_PPS;
  // Least step period with head down and no paper
  localparam int unsigned NOPAPER_STEP_CYC = (CLK_HZ + NOPAPER_PPS - 1) / NOPAPER_PPS;
  localparam int unsigned DEBOUNCE_US = 1000;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FWD_TAKEUP_LINES = 4;
  localparam int unsigned REV_TAKEUP_LINES = 10;

  // Register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PERIOD_OFS = 8'h04;
  localparam logic [7:0] MOVE_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

  // Control fields
  localparam int unsigned CTRL_TAKEUP_LSB = 0;  // 2 bits: 0 none, 1 fwd4, 2 rev10/fwd10
  localparam int unsigned CTRL_HEAD_DOWN_BIT = 2;
  localparam int unsigned CTRL_STROBE_BIT = 3;
  localparam int unsigned CTRL_CUTTER_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h02;
  localparam logic [23:0] PERIOD_RST = 24'(MIN_STEP_CYC);

  // Move fields: count in low 16 bits, direction bit 16
  localparam int unsigned MOVE_DIR_BIT = 16;

  // Interrupt bits
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_PAPER_OUT_BIT = 1;
  localparam int unsigned IRQ_PLATEN_BIT = 2;
  localparam int unsigned IRQ_W = 3;

  typedef enum logic [1:0] {
    TAKEUP_NONE,
    TAKEUP_FWD4,
    TAKEUP_REV10
  } takeup_e;

  typedef struct packed {
    logic [3:0] phase;   // A, B, A inverse, B inverse
    logic excitation_allow;
  } motor_s;

endpackage : feed_pkg

/* input_filter.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser followed by a stable-count debounce
module input_filter #(
  parameter int unsigned CYC = feed_pkg::DEBOUNCE_CYC
) (
  input wire logic core_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic raw_in, // Raw switch level
  output logic clean_out // Debounced level
);
  logic s1_r;
  logic s2_r;
  logic [$clog2(CYC+1)-1:0] cnt_r;

  // Synchroniser pair
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
    end
  end

  // Accept a new level once it stays put for CYC cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      clean_out <= 1'b0;
    end else if (s2_r == clean_out) begin
      cnt_r <= '0;
    end else if (cnt_r == ($clog2(CYC+1))'(CYC - 1)) begin
      cnt_r <= '0;
      clean_out <= s2_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule // input_filter
`default_nettype wire

/* feed_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Never step faster than 640 steps per second.
// - Forward walks excitation steps 1 to 4 and wraps.
// - Excitation allow high energises windings per phase outputs.
// - Excitation allow low leaves windings unexcited.
// - After a move, hold the last phase one more step period.
// - After the stopping step, drop excitation at standstill.
// - New move during stopping step continues stepping directly.
// - Restart from standstill excites remembered phase one period first.
// - Optional take-up: four lines forward after standstill restart.
// - Preferred take-up: ten lines reverse then ten forward.
// - Head down without paper limits stepping to 125 steps per second.
// - Block head strobe while paper is out.
// - Remove cutter power while platen is open.
// - Plain feed default period is 640 steps per second.
module feed_sequencer #(
  parameter int unsigned DEB_CYC = feed_pkg::DEBOUNCE_CYC,
  parameter int unsigned MIN_CYC = feed_pkg::MIN_STEP_CYC,
  parameter int unsigned SLOW_CYC = feed_pkg::NOPAPER_STEP_CYC
) (
  input wire logic core_clk, // System clock, 20 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic paper_present, // Paper sensor, high with paper
  input wire logic platen_closed, // Platen switch, high when closed
  input wire logic head_strobe_req, // Strobe request from head path
  output logic head_strobe, // Gated head strobe, high energises
  output logic cutter_power, // Cutter supply enable
  output feed_pkg::motor_s motor, // Phase outputs and excitation allow
  output logic irq // Level interrupt
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRE,
    ST_STEP,
    ST_STOP
  } state_e;

  state_e state_r;
  localparam int unsigned IRQ_W_L = feed_pkg::IRQ_W;
  logic [4:0] ctrl_r;
  logic [23:0] period_r;
  logic [IRQ_W_L-1:0] irq_stat_r;
  logic [IRQ_W_L-1:0] irq_mask_r;
  logic [15:0] remain_r;
  logic dir_rev_r;
  logic [1:0] idx_r;
  logic [23:0] tick_r;
  logic [1:0] tk_phase_r; // 0 none, 1 fwd4/rev10, 2 fwd10 leg
  logic [15:0] pend_cnt_r;
  logic pend_dir_r;
  logic pend_r;
  logic paper_ok;
  logic platen_ok;
  logic paper_ok_d_r;
  logic platen_ok_d_r;
  logic wr_en;
  logic rd_en;
  logic tick_done;
  logic [23:0] eff_period;
  logic done_ev;
  logic start_req;

  // Excitation table lookup, step index 0..3 is step 1..4
  function automatic logic [3:0] phase_of(input logic [1:0] idx);
    unique case (idx)
      2'd0: phase_of = 4'b0011;
      2'd1: phase_of = 4'b0110;
      2'd2: phase_of = 4'b1100;
      2'd3: phase_of = 4'b1001;
    endcase
  endfunction

  // Next table index, walking down for reverse feed
  function automatic logic [1:0] next_idx(input logic [1:0] idx, input logic rev);
    next_idx = rev ? idx - 2'd1 : idx + 2'd1;
  endfunction

  // Sensor conditioning
  input_filter #(.CYC(DEB_CYC)) u_paper (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .raw_in(paper_present),
    .clean_out(paper_ok)
  );
  input_filter #(.CYC(DEB_CYC)) u_platen (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .raw_in(platen_closed),
    .clean_out(platen_ok)
  );

  // APB decode, zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  always_comb begin
    unique case (paddr)
      feed_pkg::CTRL_OFS, feed_pkg::PERIOD_OFS, feed_pkg::MOVE_OFS,
      feed_pkg::STATUS_OFS, feed_pkg::IRQ_STAT_OFS, feed_pkg::IRQ_MASK_OFS:
        pslverr = 1'b0;
      default: pslverr = psel && penable;
    endcase
  end

  // Read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        feed_pkg::CTRL_OFS: prdata = {27'h0, ctrl_r};
        feed_pkg::PERIOD_OFS: prdata = {8'h00, period_r};
        feed_pkg::MOVE_OFS: prdata = {15'h0, dir_rev_r, remain_r};
        feed_pkg::STATUS_OFS:
          prdata = {24'h0, platen_ok, paper_ok, motor.excitation_allow,
            idx_r, state_r};
        feed_pkg::IRQ_STAT_OFS: prdata = {29'h0, irq_stat_r};
        feed_pkg::IRQ_MASK_OFS: prdata = {29'h0, irq_mask_r};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= feed_pkg::CTRL_RST;
      period_r <= feed_pkg::PERIOD_RST;
      irq_mask_r <= '0;
    end else if (wr_en) begin
      if (paddr == feed_pkg::CTRL_OFS) ctrl_r <= pwdata[4:0];
      if (paddr == feed_pkg::PERIOD_OFS) period_r <= pwdata[23:0];
      if (paddr == feed_pkg::IRQ_MASK_OFS) irq_mask_r <= pwdata[IRQ_W_L-1:0];
    end
  end

  // Move request latch; a write of a zero count is ignored
  assign start_req = wr_en && (paddr == feed_pkg::MOVE_OFS) && (pwdata[15:0] != 16'h0000);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      pend_cnt_r <= '0;
      pend_dir_r <= 1'b0;
    end else if (start_req) begin
      pend_r <= 1'b1;
      pend_cnt_r <= pwdata[15:0];
      pend_dir_r <= pwdata[feed_pkg::MOVE_DIR_BIT];
    end else if (state_r == ST_IDLE || (state_r == ST_STOP && tick_done)) begin
      pend_r <= 1'b0;
    end
  end

  // Step period clamped to the least legal period
  always_comb begin
    eff_period = period_r;
    if (eff_period < 24'(MIN_CYC)) eff_period = 24'(MIN_CYC);
    if (ctrl_r[feed_pkg::CTRL_HEAD_DOWN_BIT] && !paper_ok && eff_period < 24'(SLOW_CYC))
      eff_period = 24'(SLOW_CYC);
  end
  assign tick_done = (tick_r >= eff_period - 24'd1);

  // Step sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      idx_r <= 2'd0;
      tick_r <= '0;
      remain_r <= '0;
      dir_rev_r <= 1'b0;
      tk_phase_r <= 2'd0;
      done_ev <= 1'b0;
    end else begin
      done_ev <= 1'b0;
      tick_r <= tick_done ? 24'd0 : tick_r + 24'd1;
      unique case (state_r)
        ST_IDLE: begin
          tick_r <= '0;
          if (pend_r) begin
            state_r <= ST_PRE;
            unique case (feed_pkg::takeup_e'(ctrl_r[1:0]))
              feed_pkg::TAKEUP_FWD4: begin
                tk_phase_r <= 2'd1;
                remain_r <= 16'(feed_pkg::FWD_TAKEUP_LINES);
                dir_rev_r <= 1'b0;
              end
              feed_pkg::TAKEUP_REV10: begin
                tk_phase_r <= 2'd1;
                remain_r <= 16'(feed_pkg::REV_TAKEUP_LINES);
                dir_rev_r <= 1'b1;
              end
              default: begin
                tk_phase_r <= 2'd0;
                remain_r <= pend_cnt_r;
                dir_rev_r <= pend_dir_r;
              end
            endcase
          end
        end
        // Remembered phase held one period, then the first step
        ST_PRE: if (tick_done) begin
          state_r <= ST_STEP;
          idx_r <= next_idx(idx_r, dir_rev_r);
        end
        // Phase moves at the start of each step period
        ST_STEP: if (tick_done) begin
          if (remain_r == 16'd1) begin
            if (tk_phase_r == 2'd1 && dir_rev_r) begin
              tk_phase_r <= 2'd2;
              remain_r <= 16'(feed_pkg::REV_TAKEUP_LINES);
              dir_rev_r <= 1'b0;
              idx_r <= next_idx(idx_r, 1'b0);
            end else if (tk_phase_r != 2'd0) begin
              tk_phase_r <= 2'd0;
              remain_r <= pend_cnt_r;
              dir_rev_r <= pend_dir_r;
              idx_r <= next_idx(idx_r, pend_dir_r);
            end else begin
              state_r <= ST_STOP;
              remain_r <= '0;
            end
          end else begin
            // Each step feeds one dot line
            remain_r <= remain_r - 16'd1;
            idx_r <= next_idx(idx_r, dir_rev_r);
          end
        end
        // Stopping step keeps the last phase for a full period
        ST_STOP: if (tick_done) begin
          if (pend_r) begin
            state_r <= ST_STEP;
            remain_r <= pend_cnt_r;
            dir_rev_r <= pend_dir_r;
            idx_r <= next_idx(idx_r, pend_dir_r);
          end else begin
            state_r <= ST_IDLE;
            done_ev <= 1'b1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Motor pins from flip-flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      motor <= '{phase: 4'b0011, excitation_allow: 1'b0};
    end else begin
      motor.phase <= phase_of(idx_r);
      motor.excitation_allow <= (state_r != ST_IDLE);
    end
  end

  // Head and cutter gating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      head_strobe <= 1'b0;
      cutter_power <= 1'b0;
    end else begin
      head_strobe <= head_strobe_req && ctrl_r[feed_pkg::CTRL_STROBE_BIT] && paper_ok;
      cutter_power <= ctrl_r[feed_pkg::CTRL_CUTTER_BIT] && platen_ok;
    end
  end

  // Sticky interrupt status, set wins over write-one clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= '0;
      paper_ok_d_r <= 1'b0;
      platen_ok_d_r <= 1'b0;
    end else begin
      paper_ok_d_r <= paper_ok;
      platen_ok_d_r <= platen_ok;
      irq_stat_r <= (irq_stat_r & ~((wr_en && paddr == feed_pkg::IRQ_STAT_OFS) ?
        pwdata[IRQ_W_L-1:0] : 3'b000)) |
        {platen_ok_d_r && !platen_ok, paper_ok_d_r && !paper_ok, done_ev};
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);
endmodule // feed_sequencer
`default_nettype wire

/* feed_sequencer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// Pin-level watcher for the paper feed sequencer
module feed_checker #(
  parameter int unsigned DEB_CYC = 4,
  parameter int unsigned MIN_CYC = 8
) (
  input wire logic core_clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pslverr, // APB error
  input wire logic paper_present, // Raw paper level
  input wire logic platen_closed, // Raw platen level
  input wire logic head_strobe_req, // Strobe request
  input wire logic head_strobe, // Gated strobe
  input wire logic cutter_power, // Cutter supply
  input wire feed_pkg::motor_s motor // Motor pins
);
  logic [31:0] gap_r, exc_r, out_r, open_r;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Run lengths since a phase change, of allow, of paper out, of platen open
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= 32'h7FFF_FFFF;
      exc_r <= 32'h0;
      out_r <= 32'h0;
      open_r <= 32'h0;
    end else begin
      gap_r <= $changed(motor.phase) ? 32'h1 : gap_r + 32'h1;
      exc_r <= motor.excitation_allow ? exc_r + 32'h1 : 32'h0;
      out_r <= paper_present ? 32'h0 : out_r + 32'h1;
      open_r <= platen_closed ? 32'h0 : open_r + 32'h1;
    end
  end
  AST_PHASE_CODE:
    assert property (motor.phase inside {4'h3, 4'h6, 4'hC, 4'h9}) else $error("bad phase code");
  AST_NEIGHBOUR:
    assert property ($changed(motor.phase) |-> $countones(motor.phase ^ $past(motor.phase)) == 2)
    else $error("phase skipped a step");
  AST_STEP_RATE:
    assert property ($changed(motor.phase) |-> gap_r >= MIN_CYC) else $error("step too fast");
  AST_EXCITED_STEP:
    assert property ($changed(motor.phase) |-> motor.excitation_allow && $past(motor.excitation_allow))
    else $error("step while unexcited");
  AST_PRE_EXCITE:
    assert property ($changed(motor.phase) |-> exc_r >= MIN_CYC - 1) else $error("no pre excite");
  AST_STOP_HOLD:
    assert property ($fell(motor.excitation_allow) |-> gap_r >= MIN_CYC) else $error("short stop");
  AST_STROBE_REQ:
    assert property (head_strobe |-> $past(head_strobe_req)) else $error("strobe without request");
  AST_STROBE_PAPER:
    assert property (head_strobe |-> out_r < DEB_CYC + 6) else $error("strobe with paper out");
  AST_CUTTER_OPEN:
    assert property (cutter_power |-> open_r < DEB_CYC + 6) else $error("cutter on, platen open");
  AST_ERR_ACCESS:
    assert property (pslverr |-> psel && penable) else $error("error outside access");
endmodule // feed_checker
bind feed_sequencer feed_checker #(.DEB_CYC(DEB_CYC), .MIN_CYC(MIN_CYC)) i_chk (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pslverr(pslverr),
  .paper_present(paper_present), .platen_closed(platen_closed),
  .head_strobe_req(head_strobe_req), .head_strobe(head_strobe),
  .cutter_power(cutter_power), .motor(motor));
`default_nettype wire

/* feed_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Bipolar driver and feed motor, counting paper in dot lines
module feed_motor_model (
  input wire logic core_clk, // System clock
  input wire feed_pkg::motor_s motor // Phases and allow
);
  int pos = 0; // Paper position
  int steps = 0; // Steps taken
  int drops = 0; // Excitation releases
  int low = 0; // Lowest position since excitation
  int gap = 0; // Cycles between last two steps
  int cyc = 0; // Free cycle count
  int last = 0; // Cycle of last step
  int d; // Direction of this step
  logic [3:0] ph = 4'h3; // Phase seen last cycle
  logic en = 1'b0; // Allow seen last cycle
  function automatic int idx(logic [3:0] p);
    return p == 4'h3 ? 0 : p == 4'h6 ? 1 : p == 4'hC ? 2 : 3;
  endfunction
  // Rotor follows the phase table only while energised
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    ph <= motor.phase;
    en <= motor.excitation_allow;
    d = (idx(motor.phase) - idx(ph) + 4) % 4 == 1 ? 1 : -1;
    if (en && motor.excitation_allow && motor.phase != ph) begin
      pos <= pos + d;
      if (pos + d < low) low <= pos + d;
      steps <= steps + 1;
      gap <= cyc - last;
      last <= cyc;
    end
    if (!en && motor.excitation_allow) low <= pos;
    if (en && !motor.excitation_allow) drops <= drops + 1;
  end
endmodule // feed_motor_model
`default_nettype wire

/* feed_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
module feed_sequencer_test;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, e;
  logic paper_present, platen_closed, head_strobe_req, head_strobe, cutter_power;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  feed_pkg::motor_s motor;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int p0, s0, d0;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic err;} row_s;
  row_s rows [13] = '{'{1'b0, 8'h00, 32'h2, 1'b0}, '{1'b0, 8'h04, 32'(feed_pkg::PERIOD_RST), 1'b0},
    '{1'b0, 8'h14, 32'h0, 1'b0}, '{1'b0, 8'h10, 32'h0, 1'b0}, '{1'b0, 8'h0C, 32'hC0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 1'b0}, '{1'b1, 8'h00, 32'h18, 1'b0},
    '{1'b0, 8'h00, 32'h18, 1'b0}, '{1'b1, 8'h04, 32'h4, 1'b0}, '{1'b0, 8'h04, 32'h4, 1'b0},
    '{1'b1, 8'h14, 32'h1, 1'b0}, '{1'b1, 8'h18, 32'h5, 1'b1}, '{1'b0, 8'h1C, 32'h0, 1'b1}};
  feed_sequencer #(.DEB_CYC(4), .MIN_CYC(8), .SLOW_CYC(20)) i_dut (.core_clk(core_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .paper_present(paper_present), .platen_closed(platen_closed),
    .head_strobe_req(head_strobe_req), .head_strobe(head_strobe),
    .cutter_power(cutter_power), .motor(motor), .irq(irq));
  feed_motor_model i_motor (.core_clk(core_clk), .motor(motor));
  task automatic chk(string n, logic [31:0] x, logic [31:0] y);
    samples_checked++;
    if (y !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, x, y);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] v,
                     output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    v = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h0, r, e);
    chk("register", x, r);
  endtask
  task automatic snap;
    p0 = i_motor.pos;
    s0 = i_motor.steps;
    d0 = i_motor.drops;
  endtask
  // Waits for move done, checks travel, then clears the done flag
  task automatic fin(int dp, int ds, int gp);
    int k = 0;
    while (irq !== 1'b1 && k < 4000) begin
      @(posedge core_clk);
      k++;
    end
    repeat (2) @(posedge core_clk);
    chk("irq", 32'h1, 32'(irq));
    chk("allow", 32'h0, 32'(motor.excitation_allow));
    chk("lines", 32'(p0 + dp), 32'(i_motor.pos));
    chk("steps", 32'(s0 + ds), 32'(i_motor.steps));
    chk("drops", 32'(d0 + 1), 32'(i_motor.drops));
    chk("gap", 32'(gp), 32'(i_motor.gap));
    wr(8'h10, 32'h1);
    chk("irq", 32'h0, 32'(irq));
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, head_strobe_req} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    paper_present = 1'b1;
    platen_closed = 1'b1;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    chk("phase", 32'h3, 32'(motor.phase));
    repeat (20) @(posedge core_clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, r, e);
      chk("pslverr", 32'(rows[i].err), 32'(e));
      if (!rows[i].w && !rows[i].err) chk("prdata", rows[i].d, r);
    end
    snap();
    wr(8'h08, 32'h3);
    fin(3, 3, 8);
    snap();
    wr(8'h08, 32'h1_0002);
    fin(-2, 2, 8);
    snap();
    wr(8'h08, 32'h2);
    repeat (12) @(posedge core_clk);
    wr(8'h08, 32'h2);
    fin(4, 4, 8);
    wr(8'h00, 32'h19);
    snap();
    wr(8'h08, 32'h2);
    fin(6, 6, 8);
    wr(8'h00, 32'h1A);
    snap();
    wr(8'h08, 32'h1);
    fin(1, 21, 8);
    chk("lowest", 32'(p0 - 10), 32'(i_motor.low));
    wr(8'h00, 32'h1C);
    paper_present <= 1'b0;
    head_strobe_req <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk("strobe", 32'h0, 32'(head_strobe));
    rd(8'h10, 32'h2);
    snap();
    wr(8'h08, 32'h2);
    fin(2, 2, 20);
    wr(8'h14, 32'h3);
    chk("irq", 32'h1, 32'(irq));
    wr(8'h10, 32'h2);
    chk("irq", 32'h0, 32'(irq));
    paper_present <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk("strobe", 32'h1, 32'(head_strobe));
    paper_present <= 1'b0;
    repeat (2) @(posedge core_clk);
    paper_present <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk("strobe", 32'h1, 32'(head_strobe));
    rd(8'h10, 32'h0);
    chk("cutter", 32'h1, 32'(cutter_power));
    platen_closed <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk("cutter", 32'h0, 32'(cutter_power));
    rd(8'h10, 32'h4);
    // Reset in the middle of a move drops the windings at once
    wr(8'h08, 32'h5);
    repeat (30) @(posedge core_clk);
    chk("allow", 32'h1, 32'(motor.excitation_allow));
    rst_n <= 1'b0;
    @(posedge core_clk);
    chk("allow", 32'h0, 32'(motor.excitation_allow));
    chk("phase", 32'h3, 32'(motor.phase));
    repeat (9) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h2);
    rd(8'h04, 32'(feed_pkg::PERIOD_RST));
    rd(8'h08, 32'h0);
    summarize();
  end
endmodule // feed_sequencer_test
`default_nettype wire
